// >>> design/clock_source_startup_control.sv
// Contract
// RL1: decode four fuse bits into clock source kind
// RL2: fuse bit one means unprogrammed, zero programmed
// RL3: deep sleep wake counts source cycles first
// RL4: reset start adds watchdog-timed delay
// RL5: short delay 4096, long delay 65536 watchdog cycles
// RL6: delivered fuses 0001 and 10
// RL7: crystal range from upper three select bits
// RL8: option fuse picks full or reduced swing
// RL9: crystal low group start-up table
// RL10: crystal high group start-up table
// RL11: 258-cycle options only for resonators, slow use
// RL12: watch crystal code 1001, option adds load caps
// RL13: watch crystal start-up table, code 11 reserved
// RL14: core clock stops all core work
// RL15: peripheral clock; async interrupts still detected
// RL16: two-wire address match works clock halted
// RL17: program memory clock follows core clock
// RL18: async timer clock only on internal oscillator
// RL19: converter clock runs while core clocks halted
// RL20: sleep mode selects which clocks gate
// RL21: resonator limited to 8 or 16 MHz
// RL22: release core and peripheral clocks together
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module clock_source_startup_control #(
    parameter int unsigned ADDR_W = 8,
    parameter logic [16:0] LONG_DELAY_CYCLES = 17'h10000,
    parameter logic [16:0] CRYSTAL_LONG_CYCLES = 17'h04000,
    parameter logic [16:0] LOWFREQ_LONG_CYCLES = 17'h08000,
    parameter logic [16:0] OTHER_SOURCE_CYCLES = 17'h00006
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic source_osc_in, // selected source, squared
    input wire logic watchdog_osc_in, // watchdog oscillator
    input wire logic ext_int_async, // async external interrupt
    input wire logic twi_addr_match, // two-wire address match
    output logic core_clock_en, // core clock gate
    output logic peripheral_clock_en, // peripheral clock gate
    output logic program_memory_clock_en, // program memory gate
    output logic async_timer_clock_en, // async timer clock gate
    output logic converter_clock_en, // converter clock gate
    output logic oscillator_en, // main oscillator running
    output logic full_swing, // rail-to-rail amplifier
    output logic [2:0] amp_range, // crystal amplifier range
    output logic load_caps_en // internal load capacitors
);

    // decode select fuses into a source kind
    function automatic logic [2:0] decode_kind(input logic [3:0] sel);
        if (sel >= clock_startup_pkg::SEL_CRYSTAL_MIN)
            return clock_startup_pkg::SRC_CRYSTAL;
        else if (sel == clock_startup_pkg::SEL_LOWFREQ)
            return clock_startup_pkg::SRC_LOWFREQ;
        else if (sel >= clock_startup_pkg::SEL_EXT_RC_MIN)
            return clock_startup_pkg::SRC_EXT_RC;
        else if (sel >= clock_startup_pkg::SEL_INT_RC_MIN)
            return clock_startup_pkg::SRC_INT_RC;
        else
            return clock_startup_pkg::SRC_EXT_CLK;
    endfunction

    // source cycles to wait before the clocks may run
    function automatic logic [16:0] source_cycles(input logic [2:0] kind,
        input logic grp, input logic [1:0] sut);
        if (kind == clock_startup_pkg::SRC_CRYSTAL)
        begin
            if (!grp)
                return sut[1] ? clock_startup_pkg::CYC_1K
                              : clock_startup_pkg::CYC_258;
            else
                return (sut == 2'h0) ? clock_startup_pkg::CYC_1K
                                     : CRYSTAL_LONG_CYCLES;
        end
        else if (kind == clock_startup_pkg::SRC_LOWFREQ)
            return sut[1] ? LOWFREQ_LONG_CYCLES : clock_startup_pkg::CYC_1K;
        else
            return OTHER_SOURCE_CYCLES;
    endfunction

    // extra delay after reset, in watchdog cycles
    function automatic logic [1:0] delay_code(input logic [2:0] kind,
        input logic grp, input logic [1:0] sut);
        logic [3:0] key;
        key = {grp, sut, 1'b0};
        if (kind == clock_startup_pkg::SRC_CRYSTAL)
        begin
            case (key[3:1])
                3'h0: return clock_startup_pkg::DELAY_SHORT;
                3'h1: return clock_startup_pkg::DELAY_LONG;
                3'h2: return clock_startup_pkg::DELAY_NONE;
                3'h3: return clock_startup_pkg::DELAY_SHORT;
                3'h4: return clock_startup_pkg::DELAY_LONG;
                3'h5: return clock_startup_pkg::DELAY_NONE;
                3'h6: return clock_startup_pkg::DELAY_SHORT;
                default: return clock_startup_pkg::DELAY_LONG;
            endcase
        end
        else if (kind == clock_startup_pkg::SRC_LOWFREQ)
            return (sut == 2'h0) ? clock_startup_pkg::DELAY_SHORT
                                 : clock_startup_pkg::DELAY_LONG;
        else
        begin
            case (sut)
                2'h0: return clock_startup_pkg::DELAY_NONE;
                2'h2: return clock_startup_pkg::DELAY_LONG;
                default: return clock_startup_pkg::DELAY_SHORT;
            endcase
        end
    endfunction

    clock_startup_pkg::startup_state_t state;
    clock_startup_pkg::startup_state_t next_state;
    logic [31:0] fuse_reg;
    logic [2:0] sleep_mode;
    logic async_enable;
    logic conv_enable;
    logic sleep_req;
    logic from_reset;
    logic [16:0] cycle_count;
    logic [16:0] next_count;
    logic [3:0] sync_1;
    logic [3:0] sync_2;
    logic [1:0] tick_prev;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_byte0;
    logic reserved_code;

    // two-flop synchronisers on every pin input
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_1 <= 4'h0;
            sync_2 <= 4'h0;
            tick_prev <= 2'h0;
        end
        else
        begin
            sync_1 <= {twi_addr_match, ext_int_async, watchdog_osc_in,
                       source_osc_in};
            sync_2 <= sync_1;
            tick_prev <= sync_2[1:0];
        end
    end

    // rising edges of the two counted oscillators
    wire src_tick = sync_2[0] & ~tick_prev[0];
    wire wdt_tick = sync_2[1] & ~tick_prev[1];
    // async wake paths do not need the peripheral clock running
    wire wake = sync_2[2] | sync_2[3]; // RL15 RL16

    // fuse field decode; option reads zero when programmed
    wire [3:0] src_sel = fuse_reg[clock_startup_pkg::FUSE_SRC_LSB +: 4];
    wire [1:0] sut = fuse_reg[clock_startup_pkg::FUSE_SUT_LSB +: 2];
    wire opt_programmed = ~fuse_reg[clock_startup_pkg::FUSE_OPT_BIT]; // RL2
    wire [2:0] kind = decode_kind(src_sel); // RL1
    wire is_crystal = (kind == clock_startup_pkg::SRC_CRYSTAL);
    wire is_lowfreq = (kind == clock_startup_pkg::SRC_LOWFREQ);
    wire [16:0] src_target =
        source_cycles(kind, src_sel[0], sut); // RL9 RL10 RL13
    wire [1:0] dcode = delay_code(kind, src_sel[0], sut); // RL9 RL10 RL13
    // selecting the delay table entry by watchdog count
    wire [16:0] delay_target =
        (dcode == clock_startup_pkg::DELAY_LONG) ? LONG_DELAY_CYCLES :
        clock_startup_pkg::CYC_4K; // RL5
    wire in_delay = (state == clock_startup_pkg::st_reset_delay);
    wire [16:0] target = in_delay ? delay_target : src_target;
    wire [16:0] target_m1 = target - clock_startup_pkg::CYC_ONE;
    wire tick = in_delay ? wdt_tick : src_tick; // RL4
    wire count_done = tick && (cycle_count == target_m1);
    wire deep_mode = (sleep_mode == clock_startup_pkg::MODE_POWER_DOWN) ||
                     (sleep_mode == clock_startup_pkg::MODE_POWER_SAVE);

    // start-up sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            clock_startup_pkg::st_source_count:
                if (count_done)
                    next_state = (from_reset &&
                        dcode != clock_startup_pkg::DELAY_NONE)
                        ? clock_startup_pkg::st_reset_delay // RL4
                        : clock_startup_pkg::st_run; // RL22
            clock_startup_pkg::st_reset_delay:
                if (count_done)
                    next_state = clock_startup_pkg::st_run; // RL22
            clock_startup_pkg::st_run:
                if (sleep_req)
                    next_state = clock_startup_pkg::st_sleep;
            clock_startup_pkg::st_sleep:
                if (wake)
                    next_state = deep_mode
                        ? clock_startup_pkg::st_source_count // RL3
                        : clock_startup_pkg::st_run;
            default:
                next_state = clock_startup_pkg::st_source_count;
        endcase
    end

    // counter restarts whenever the sequencer moves
    assign next_count = (next_state != state) ? 17'h00000 :
                        tick ? cycle_count + clock_startup_pkg::CYC_ONE :
                        cycle_count;

    // gating per sleep mode; oscillator off in the deepest modes
    wire n_run = (next_state == clock_startup_pkg::st_run);
    wire n_sleep = (next_state == clock_startup_pkg::st_sleep);
    wire m_idle = (sleep_mode == clock_startup_pkg::MODE_IDLE);
    wire m_noise = (sleep_mode == clock_startup_pkg::MODE_NOISE);
    wire m_save = (sleep_mode == clock_startup_pkg::MODE_POWER_SAVE);
    wire next_core = n_run; // RL14 RL22
    wire next_periph = n_run | (n_sleep & m_idle); // RL20 RL22
    wire next_conv = conv_enable &
        (n_run | (n_sleep & (m_idle | m_noise))); // RL19
    // a 32 kHz timer crystal needs a much faster main clock
    wire async_ok = async_enable &&
        (kind == clock_startup_pkg::SRC_INT_RC); // RL18
    wire next_async = async_ok &
        (n_run | (n_sleep & (m_idle | m_noise | m_save))); // RL20
    wire next_osc = ~(n_sleep & deep_mode);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= clock_startup_pkg::st_source_count;
            cycle_count <= 17'h00000;
            from_reset <= 1'b1;
            core_clock_en <= 1'b0;
            program_memory_clock_en <= 1'b0;
            peripheral_clock_en <= 1'b0;
            converter_clock_en <= 1'b0;
            async_timer_clock_en <= 1'b0;
            oscillator_en <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cycle_count <= next_count; // RL3 RL5
            from_reset <= from_reset & ~n_run;
            core_clock_en <= next_core; // RL14
            program_memory_clock_en <= next_core; // RL17
            peripheral_clock_en <= next_periph; // RL15
            converter_clock_en <= next_conv; // RL19
            async_timer_clock_en <= next_async; // RL18
            oscillator_en <= next_osc; // RL20
        end
    end

    // amplifier and capacitor controls from the fuses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            full_swing <= 1'b0;
            amp_range <= 3'h0;
            load_caps_en <= 1'b0;
            reserved_code <= 1'b0;
        end
        else
        begin
            full_swing <= opt_programmed; // RL8
            amp_range <= is_crystal ? src_sel[3:1] : 3'h0; // RL7
            load_caps_en <= is_lowfreq & opt_programmed; // RL12
            reserved_code <= is_lowfreq && (sut == 2'h3); // RL13
        end
    end

    // write path: address and data taken in either order
    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire wr_fire = ~awready & ~wready & ~bvalid;
    wire wr_fuse = (wr_addr == clock_startup_pkg::ADDR_FUSE);
    wire wr_ctrl = (wr_addr == clock_startup_pkg::ADDR_CTRL);
    wire wr_ro = (wr_addr == clock_startup_pkg::ADDR_STATUS) ||
                 (wr_addr == clock_startup_pkg::ADDR_TARGET);
    wire wr_ok = wr_fuse | wr_ctrl | wr_ro;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= clock_startup_pkg::RESP_OKAY;
            wr_addr <= '0;
            wr_data <= 32'h00000000;
            wr_byte0 <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                wr_addr <= awaddr;
                awready <= 1'b0;
            end
            if (w_hs)
            begin
                wr_data <= wdata;
                wr_byte0 <= wstrb[0];
                wready <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? clock_startup_pkg::RESP_OKAY
                               : clock_startup_pkg::RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // fuse and control storage; sleep request wins over its clear
    wire do_fuse = wr_fire & wr_fuse & wr_byte0;
    wire do_ctrl = wr_fire & wr_ctrl & wr_byte0;
    wire set_sleep = do_ctrl & wr_data[clock_startup_pkg::CTRL_SLEEP_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fuse_reg <= clock_startup_pkg::FUSE_RESET; // RL6
            sleep_mode <= clock_startup_pkg::MODE_IDLE;
            async_enable <= 1'b0;
            conv_enable <= 1'b0;
            sleep_req <= 1'b0;
        end
        else
        begin
            if (do_fuse)
                fuse_reg <= {25'h0000000, wr_data[6:0]};
            if (do_ctrl)
            begin
                sleep_mode <= wr_data[clock_startup_pkg::CTRL_MODE_LSB +: 3];
                async_enable <= wr_data[clock_startup_pkg::CTRL_ASYNC_BIT];
                conv_enable <= wr_data[clock_startup_pkg::CTRL_CONV_BIT];
            end
            sleep_req <= set_sleep | (sleep_req & ~n_sleep); // RL20
        end
    end

    // read path: one cycle after the address is taken
    wire [31:0] ctrl_rd = {26'h0000000, conv_enable, async_enable,
                           sleep_req, sleep_mode};
    wire [31:0] status_rd = {18'h00000, n_run, reserved_code,
                             load_caps_en, full_swing, amp_range, kind,
                             state};
    wire rd_fuse = (araddr == clock_startup_pkg::ADDR_FUSE);
    wire rd_ctrl = (araddr == clock_startup_pkg::ADDR_CTRL);
    wire rd_stat = (araddr == clock_startup_pkg::ADDR_STATUS);
    wire rd_targ = (araddr == clock_startup_pkg::ADDR_TARGET);
    wire [31:0] rd_mux = rd_fuse ? fuse_reg :
                         rd_ctrl ? ctrl_rd :
                         rd_stat ? status_rd :
                         rd_targ ? {15'h0000, target} : 32'h00000000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= clock_startup_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= (rd_fuse | rd_ctrl | rd_stat | rd_targ)
                ? clock_startup_pkg::RESP_OKAY
                : clock_startup_pkg::RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_gated_in_startup: assert property ( // RL22
        (state == clock_startup_pkg::st_source_count ||
         state == clock_startup_pkg::st_reset_delay)
        |-> !core_clock_en && !peripheral_clock_en)
        else $error("clocks running during start-up");
    a_release_together: assert property ( // RL22
        ($past(state) == clock_startup_pkg::st_reset_delay &&
         state == clock_startup_pkg::st_run)
        |-> $rose(core_clock_en) && $rose(peripheral_clock_en))
        else $error("core and peripheral not released together");
    a_core_memory_pair: assert property ( // RL17
        core_clock_en == program_memory_clock_en)
        else $error("program memory clock apart from core clock");
    a_core_off_sleep: assert property ( // RL14
        state == clock_startup_pkg::st_sleep |-> !core_clock_en)
        else $error("core clock on in sleep");
    a_delay_count: assert property ( // RL5
        (in_delay && next_state == clock_startup_pkg::st_run)
        |-> wdt_tick && cycle_count == delay_target - 17'h00001)
        else $error("reset delay ended at wrong count");
    a_deep_wake_count: assert property ( // RL3
        (state == clock_startup_pkg::st_sleep && deep_mode && wake)
        |=> state == clock_startup_pkg::st_source_count ##0 !core_clock_en)
        else $error("deep sleep wake skipped source count");
    a_async_internal: assert property ( // RL18
        async_timer_clock_en |-> $past(kind) == clock_startup_pkg::SRC_INT_RC)
        else $error("async timer clock without internal oscillator");
    a_noise_mode_gate: assert property ( // RL19
        (state == clock_startup_pkg::st_sleep && m_noise && conv_enable &&
         $stable(state)) |-> converter_clock_en && !peripheral_clock_en)
        else $error("wrong gating in noise reduction sleep");
    a_caps_lowfreq: assert property ( // RL12
        load_caps_en |-> $past(src_sel) == clock_startup_pkg::SEL_LOWFREQ &&
        !$past(fuse_reg[clock_startup_pkg::FUSE_OPT_BIT]))
        else $error("load capacitors outside programmed watch crystal");
    a_swing_option: assert property ( // RL8
        ##1 full_swing == !$past(fuse_reg[clock_startup_pkg::FUSE_OPT_BIT]))
        else $error("amplifier swing does not follow option fuse");

    c_reset_to_run: cover property (
        in_delay ##1 state == clock_startup_pkg::st_run);
    c_deep_wake: cover property (
        state == clock_startup_pkg::st_sleep && deep_mode && wake);
    c_light_wake: cover property (
        state == clock_startup_pkg::st_sleep && m_idle && wake);
    c_bus_write: cover property (bvalid && bready);

endmodule // clock_source_startup_control

// >>> inc/clock_startup_pkg.sv
package clock_startup_pkg;

    // counter width, wide enough for the longest delay
    localparam int unsigned COUNT_W = 17;

    // fuse register layout; a stored one means unprogrammed
    localparam int unsigned FUSE_SRC_LSB = 0;
    localparam int unsigned FUSE_SUT_LSB = 4;
    localparam int unsigned FUSE_OPT_BIT = 6;
    localparam logic [31:0] FUSE_RESET = 32'h00000061;

    // control register layout
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_SLEEP_BIT = 3;
    localparam int unsigned CTRL_ASYNC_BIT = 4;
    localparam int unsigned CTRL_CONV_BIT = 5;

    // status register layout
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_KIND_LSB = 4;
    localparam int unsigned STAT_RANGE_LSB = 7;
    localparam int unsigned STAT_SWING_BIT = 10;
    localparam int unsigned STAT_CAPS_BIT = 11;
    localparam int unsigned STAT_RSVD_BIT = 12;
    localparam int unsigned STAT_RUN_BIT = 13;

    // register byte offsets
    localparam logic [7:0] ADDR_FUSE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TARGET = 8'h0c;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // clock source select boundaries
    localparam logic [3:0] SEL_CRYSTAL_MIN = 4'ha;
    localparam logic [3:0] SEL_LOWFREQ = 4'h9;
    localparam logic [3:0] SEL_EXT_RC_MIN = 4'h5;
    localparam logic [3:0] SEL_INT_RC_MIN = 4'h1;

    // decoded source kinds
    localparam logic [2:0] SRC_CRYSTAL = 3'h0;
    localparam logic [2:0] SRC_LOWFREQ = 3'h1;
    localparam logic [2:0] SRC_EXT_RC = 3'h2;
    localparam logic [2:0] SRC_INT_RC = 3'h3;
    localparam logic [2:0] SRC_EXT_CLK = 3'h4;

    // sleep modes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
    localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h4;

    // reset delay codes and short counts
    localparam logic [1:0] DELAY_NONE = 2'h0;
    localparam logic [1:0] DELAY_SHORT = 2'h1;
    localparam logic [1:0] DELAY_LONG = 2'h2;
    localparam logic [16:0] CYC_258 = 17'h00102;
    localparam logic [16:0] CYC_1K = 17'h00400;
    localparam logic [16:0] CYC_4K = 17'h01000;
    localparam logic [16:0] CYC_ONE = 17'h00001;

    typedef enum logic [3:0] {
        st_source_count = 4'h1,
        st_reset_delay = 4'h2,
        st_run = 4'h4,
        st_sleep = 4'h8
    } startup_state_t;

endpackage

// >>> verification/osc_model.sv
// squared oscillator as seen after the crystal pins
module osc_model #(
    parameter int HALF = 4
) (
    input wire logic aclk, // bench clock
    input wire logic run, // amplifier powered
    output logic osc = 1'b0 // squared output
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // a halted amplifier gives no edges, so the output stands low
    always @(posedge aclk)
    begin
        cnt <= run ? (cnt + 1) % (2 * HALF) : 0;
        osc <= run && (cnt >= HALF);
    end
endmodule // osc_model

// >>> verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] f; logic [7:0] st;
        logic [16:0] tg;} row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, two_wire_serial_unit = 0;
    logic src_on = 0, ext_int = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] rresp, rr, br;
    logic [2:0] amp;
    logic src, wdog, core_en, per_en, pm_en, conv_en, osc_en, fs, caps, asy;
    int miscompares = 0, cmp_count = 0, n;
    // fuse, status[11:4] = caps swing range kind, count target
    row_t rows[8] = '{'{8'h0a, 8'h68, 17'h00102}, '{8'h5b, 8'h28, 17'h00020},
        '{8'h7c, 8'h30, 17'h00400}, '{8'h09, 8'hc1, 17'h00400},
        '{8'h69, 8'h01, 17'h00030}, '{8'h45, 8'h02, 17'h00006},
        '{8'h40, 8'h04, 17'h00006}, '{8'h44, 8'h03, 17'h00006}};
    clock_source_startup_control #(.LONG_DELAY_CYCLES(17'h00010),
        .CRYSTAL_LONG_CYCLES(17'h00020), .LOWFREQ_LONG_CYCLES(17'h00030)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(br), .bvalid(bvalid), .bready(1'b1),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .source_osc_in(src),
        .watchdog_osc_in(wdog), .ext_int_async(ext_int), .twi_addr_match(two_wire_serial_unit),
        .core_clock_en(core_en), .peripheral_clock_en(per_en),
        .program_memory_clock_en(pm_en), .async_timer_clock_en(asy),
        .converter_clock_en(conv_en), .oscillator_en(osc_en), .full_swing(fs),
        .amp_range(amp), .load_caps_en(caps));
    // the main source only swings while the design powers it; kept slow
    osc_model #(.HALF(4)) src_osc (.aclk(aclk), .run(src_on && osc_en),
        .osc(src));
    osc_model #(.HALF(6)) wdog_osc (.aclk(aclk), .run(1'b1), .osc(wdog));
    initial
        forever #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            done = !(awvalid && !awready) && !(wvalid && !wready);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while (!done);
        do @(posedge aclk); while (!bvalid);
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rr = rresp;
    endtask
    task automatic wait_en(input int lim);
        for (n = 0; n < lim && core_en !== 1'b1; n++)
            @(posedge aclk);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(core_en), 32'h0);
        rdr(clock_startup_pkg::ADDR_FUSE);
        chk(rd, 32'h00000061);
        // source stalled: the sequencer stays in source count
        for (int i = 0; i < 8; i++)
        begin
            wr(clock_startup_pkg::ADDR_FUSE, 32'(rows[i].f));
            rdr(clock_startup_pkg::ADDR_STATUS);
            chk(32'(rd[11:4]), 32'(rows[i].st));
            chk(32'({caps, fs, amp}), 32'(rows[i].st[7:3]));
            rdr(clock_startup_pkg::ADDR_TARGET);
            chk(rd, 32'(rows[i].tg));
        end
        rdr(8'h10);
        chk(32'(rr), 32'(clock_startup_pkg::RESP_SLVERR));
        wr(8'h10, 32'h00000000);
        chk(32'(br), 32'(clock_startup_pkg::RESP_SLVERR));
        wr(clock_startup_pkg::ADDR_FUSE, 32'h00000061);
        src_on <= 1'b1;
        wait_en(1000);
        chk(32'({core_en, per_en, pm_en}), 32'h7);
        chk(32'(n > 180), 32'h1);
        wr(clock_startup_pkg::ADDR_CTRL, 32'h0000000a);
        repeat (3) @(posedge aclk);
        chk(32'({core_en, per_en, osc_en}), 32'h0);
        ext_int <= 1'b1;
        wait_en(150);
        chk(32'({core_en, n > 40}), 32'h3);
        ext_int <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(clock_startup_pkg::ADDR_CTRL, 32'h00000029);
        repeat (3) @(posedge aclk);
        chk(32'({conv_en, core_en}), 32'h2);
        // idle while asleep: peripheral and timer clocks come back
        wr(clock_startup_pkg::ADDR_CTRL, 32'h00000010);
        @(posedge aclk);
        chk(32'({asy, per_en, core_en}), 32'h6);
        two_wire_serial_unit <= 1'b1;
        wait_en(20);
        chk(32'(core_en), 32'h1);
        two_wire_serial_unit <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(clock_startup_pkg::ADDR_CTRL, 32'h0000001b);
        repeat (3) @(posedge aclk);
        chk(32'({asy, osc_en, per_en}), 32'h4);
        wr(clock_startup_pkg::ADDR_FUSE, 32'h00000079);
        rdr(clock_startup_pkg::ADDR_STATUS);
        chk(32'({rd[12], asy}), 32'h2);
        // reset in mid-run restores the delivered fuses
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(clock_startup_pkg::ADDR_FUSE);
        chk(32'({rd[7:0], core_en, osc_en}), 32'h185);
        wrap_up;
    end
    initial
    begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        wrap_up;
    end
endmodule // testbench
